// [logic/event_notify_pkg.sv]
// What this block does
// - selector register picks event for mode access
// - mode off: occurrence sends no notification
// - mode on: occurrences are notified, repeats while one is still pending merge into one
// - mode once: notify next, then off
// - test command always notifies, mode ignored
// - past-due valid action raises late event
// - encoder stall timeout and restart events
// - io line rise, fall, either edge events
// - link trigger rise, fall, either edge events
// - counter begin and finish events
// - timer begin and finish events
// - stream queue overflow raises event
// - stream start, end, pause, resume events
// - block start, end, trigger, burst events
// - acquisition trigger, miss, phase, error events
// - frame burst, trigger, capture, transfer events
// - line trigger, miss, start, end events
// - exposure begin and done events
// - sequencer set change raises event
// - link rate change raises event
// - general error raises event
// - controller switchover grant raises event
// - line edges seen after input inversion
// - notification carries timestamp and frame id
package event_notify_pkg;
	localparam int NUM_UNITS = 2;
	// event index map: direct-input events first, then derived groups
	localparam int EV_DIRECT   = 43;
	localparam int EV_ENC_STOP = 43;
	localparam int EV_ENC_RUN  = 45;
	localparam int EV_PIN_RISE = 47;
	localparam int EV_PIN_FALL = 49;
	localparam int EV_PIN_ANY  = 51;
	localparam int EV_RT_RISE  = 53;
	localparam int EV_RT_FALL  = 55;
	localparam int EV_RT_ANY   = 57;
	localparam int EV_LATE     = 59;
	localparam int EV_TEST     = 60;
	localparam int NUM_EVENTS  = 61;
	localparam int ID_W        = 6;
	// register map
	localparam logic [3:0] REG_SELECT   = 4'h0;
	localparam logic [3:0] REG_MODE     = 4'h1;
	localparam logic [3:0] REG_TEST     = 4'h2;
	localparam logic [3:0] REG_INVERT   = 4'h3;
	localparam logic [3:0] REG_STALL    = 4'h4;
	localparam logic [3:0] REG_PENDING  = 4'h5;
	localparam logic [5:0] SELECT_RESET = 6'h00;
	localparam logic [1:0] INVERT_RESET = 2'h0;
	localparam logic [15:0] STALL_RESET = 16'h1000;
	localparam int TS_W = 32;
	localparam int FID_W = 16;
	typedef enum logic [1:0] {MODE_OFF, MODE_ON, MODE_ONCE} notify_mode_t;
endpackage : event_notify_pkg

// [logic/device_event_notifier.sv]
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/10ps
module device_event_notifier #(
	parameter int QDEPTH = 8
) (
	// clock and reset
	input  logic                                   clock,
	input  logic                                   rst,
	// register port
	input  logic [3:0]                             reg_addr,
	input  logic [31:0]                            reg_wdata,
	input  logic                                   reg_wr,
	input  logic                                   reg_rd,
	output logic [31:0]                            reg_rdata,
	// internal occurrence pulses, one bit per direct event index
	input  logic [event_notify_pkg::EV_DIRECT-1:0] direct_events,
	// encoder motion pulses, io pins, link triggers
	input  logic [event_notify_pkg::NUM_UNITS-1:0] encoder_step,
	input  logic [event_notify_pkg::NUM_UNITS-1:0] io_pin,
	input  logic [event_notify_pkg::NUM_UNITS-1:0] remote_trig,
	// scheduled action check and message frame id
	input  logic                                   action_valid,
	input  logic [event_notify_pkg::TS_W-1:0]      action_time,
	input  logic [event_notify_pkg::TS_W-1:0]      device_time,
	input  logic [event_notify_pkg::FID_W-1:0]     frame_id,
	// notification message port and line status outputs
	output logic                                   msg_valid,
	input  logic                                   msg_ready,
	output logic [event_notify_pkg::ID_W-1:0]      msg_event,
	output logic [event_notify_pkg::TS_W-1:0]      msg_timestamp,
	output logic [event_notify_pkg::FID_W-1:0]     msg_frame_id,
	output logic                                   line_status_0,
	output logic                                   line_status_1
);
	import event_notify_pkg::*;

	localparam int QW = $clog2(QDEPTH);
	localparam int EW = ID_W + TS_W + FID_W;

	typedef struct packed {
		logic [NUM_EVENTS-1:0][1:0]  mode;
		logic [NUM_EVENTS-1:0]       pend;
		logic [5:0]                  sel;
		logic [1:0]                  invert;
		logic [15:0]                 stall;
		logic [NUM_UNITS-1:0][15:0]  idle_cnt;
		logic [NUM_UNITS-1:0]        stalled;
		logic [NUM_UNITS-1:0]        pin_s1;
		logic [NUM_UNITS-1:0]        pin_s2;
		logic [NUM_UNITS-1:0]        pin_old;
		logic [NUM_UNITS-1:0]        rt_s1;
		logic [NUM_UNITS-1:0]        rt_s2;
		logic [NUM_UNITS-1:0]        rt_old;
		logic [NUM_UNITS-1:0]        enc_s1;
		logic [NUM_UNITS-1:0]        enc_s2;
		logic [NUM_UNITS-1:0]        enc_old;
		logic                        test_req;
		logic [TS_W-1:0]             ts;
		logic [QDEPTH-1:0][EW-1:0]   fifo;
		logic [QW:0]                 wr_ptr;
		logic [QW:0]                 rd_ptr;
		logic [31:0]                 rdata;
	} state_t;

	state_t s_q;
	state_t s_d;

	logic [NUM_EVENTS-1:0] occur;
	logic [NUM_EVENTS-1:0] armed;
	logic [NUM_UNITS-1:0]  line_val;
	logic [NUM_UNITS-1:0]  step;
	logic                  full;
	logic                  empty;
	logic [ID_W-1:0]       pick;
	logic                  pick_ok;

	////////////////////////////////////////////////////////////////////////
	// occurrence detection
	always_comb begin
		line_val = s_q.pin_s2 ^ s_q.invert;
		step     = s_q.enc_s2 ^ s_q.enc_old;
		occur    = '0;
		occur[EV_DIRECT-1:0] = direct_events;
		// per-unit events derived from encoder, pin and trigger inputs
		for (int i = 0; i < NUM_UNITS; i++) begin
			occur[EV_ENC_STOP+i] = !s_q.stalled[i] && !step[i] && (s_q.idle_cnt[i] >= s_q.stall);
			occur[EV_ENC_RUN+i]  = s_q.stalled[i] && step[i];
			occur[EV_PIN_RISE+i] = line_val[i] && !s_q.pin_old[i];
			occur[EV_PIN_FALL+i] = !line_val[i] && s_q.pin_old[i];
			occur[EV_PIN_ANY+i]  = line_val[i] ^ s_q.pin_old[i];
			occur[EV_RT_RISE+i]  = s_q.rt_s2[i] && !s_q.rt_old[i];
			occur[EV_RT_FALL+i]  = !s_q.rt_s2[i] && s_q.rt_old[i];
			occur[EV_RT_ANY+i]   = s_q.rt_s2[i] ^ s_q.rt_old[i];
		end
		occur[EV_LATE] = action_valid && (action_time < device_time);
		occur[EV_TEST] = s_q.test_req;
		// gate by mode; test is always enabled
		for (int e = 0; e < NUM_EVENTS; e++) begin
			armed[e] = occur[e] && (s_q.mode[e] != MODE_OFF);
		end
		armed[EV_TEST] = occur[EV_TEST];
	end

	////////////////////////////////////////////////////////////////////////
	// queue status and lowest pending pick
	always_comb begin
		full    = (s_q.wr_ptr[QW-1:0] == s_q.rd_ptr[QW-1:0]) && (s_q.wr_ptr[QW] != s_q.rd_ptr[QW]);
		empty   = (s_q.wr_ptr == s_q.rd_ptr);
		pick    = '0;
		pick_ok = 1'b0;
		for (int e = NUM_EVENTS - 1; e >= 0; e--) begin
			if (s_q.pend[e]) begin
				pick    = ID_W'(e);
				pick_ok = 1'b1;
			end
		end
	end

	assign msg_valid     = !empty;
	assign msg_event     = s_q.fifo[s_q.rd_ptr[QW-1:0]][EW-1 -: ID_W];
	assign msg_timestamp = s_q.fifo[s_q.rd_ptr[QW-1:0]][FID_W +: TS_W];
	assign msg_frame_id  = s_q.fifo[s_q.rd_ptr[QW-1:0]][FID_W-1:0];
	assign reg_rdata     = s_q.rdata;
	assign line_status_0 = line_val[0];
	assign line_status_1 = line_val[1];

	////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		s_d = s_q;
		s_d.ts = s_q.ts + 1'b1;
		// pin inputs pass two flops before use
		s_d.pin_s1 = io_pin;
		s_d.pin_s2 = s_q.pin_s1;
		s_d.pin_old = line_val;
		s_d.rt_s1 = remote_trig;
		s_d.rt_s2 = s_q.rt_s1;
		s_d.rt_old = s_q.rt_s2;
		s_d.enc_s1 = encoder_step;
		s_d.enc_s2 = s_q.enc_s1;
		s_d.enc_old = s_q.enc_s2;
		s_d.test_req = 1'b0;
		for (int i = 0; i < NUM_UNITS; i++) begin
			if (step[i]) begin
				s_d.idle_cnt[i] = '0;
				s_d.stalled[i]  = 1'b0;
			end else if (occur[EV_ENC_STOP+i]) begin
				s_d.stalled[i] = 1'b1;
			end else if (s_q.idle_cnt[i] != 16'hffff) begin
				s_d.idle_cnt[i] = s_q.idle_cnt[i] + 1'b1;
			end
		end
		// once drops to off as soon as the occurrence is latched, so a second hit never passes
		for (int e = 0; e < NUM_EVENTS; e++) begin
			if (armed[e] && s_q.mode[e] == MODE_ONCE) begin
				s_d.mode[e] = MODE_OFF;
			end
		end
		// pop from message queue
		if (msg_valid && msg_ready) begin
			s_d.rd_ptr = s_q.rd_ptr + 1'b1;
		end
		// one pending event per cycle moves into the queue, lowest index first
		if (pick_ok && !full) begin
			s_d.fifo[s_q.wr_ptr[QW-1:0]] = {pick, s_q.ts, frame_id};
			s_d.wr_ptr = s_q.wr_ptr + 1'b1;
			s_d.pend[pick] = 1'b0;
		end
		// new occurrences set pending after the clear, so set wins
		s_d.pend = s_d.pend | armed;
		// register access
		s_d.rdata = 32'h0;
		if (reg_wr) begin
			case (reg_addr)
				REG_SELECT: s_d.sel = reg_wdata[5:0];
				REG_MODE: begin
					if (s_q.sel < 6'(NUM_EVENTS)) begin
						s_d.mode[s_q.sel] = reg_wdata[1:0];
					end
				end
				REG_TEST:   s_d.test_req = reg_wdata[0];
				REG_INVERT: s_d.invert = reg_wdata[1:0];
				REG_STALL:  s_d.stall = reg_wdata[15:0];
				default: ;
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				REG_SELECT: s_d.rdata = {26'h0, s_q.sel};
				REG_MODE:   s_d.rdata = (s_q.sel < 6'(NUM_EVENTS)) ? {30'h0, s_q.mode[s_q.sel]} : 32'h0;
				REG_INVERT: s_d.rdata = {30'h0, s_q.invert};
				REG_STALL:  s_d.rdata = {16'h0, s_q.stall};
				REG_PENDING: s_d.rdata = {27'h0, !empty, full, line_val, pick_ok};
				default:    s_d.rdata = 32'h0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge clock) begin
		if (rst) begin
			s_q        <= '0;
			s_q.sel    <= SELECT_RESET;
			s_q.invert <= INVERT_RESET;
			s_q.stall  <= STALL_RESET;
		end else begin
			s_q <= s_d;
		end
	end
endmodule : device_event_notifier

// [testbench/host_sink.sv]
`timescale 1ns/10ps
module host_sink (
	// clock and reset
	input logic clock,
	input logic rst,
	// pacing select and handshake
	input logic slow,
	output logic msg_ready
);
	logic [1:0] cnt_q;
	// slow host is ready one cycle in four, so the queue must hold data meanwhile
	always_ff @(posedge clock) cnt_q <= rst ? 2'h0 : cnt_q + 2'h1;
	assign msg_ready = !slow || cnt_q == 2'h3;
endmodule : host_sink

// [testbench/event_notify_assertions.sv]
`timescale 1ns/10ps
module event_notify_assertions import event_notify_pkg::*; (
	input logic clock,
	input logic rst,
	input logic [3:0] reg_addr,
	input logic [31:0] reg_wdata,
	input logic reg_wr,
	input logic reg_rd,
	input logic [31:0] reg_rdata,
	input logic msg_valid,
	input logic msg_ready,
	input logic [event_notify_pkg::ID_W-1:0] msg_event,
	input logic [event_notify_pkg::TS_W-1:0] msg_timestamp,
	input logic [event_notify_pkg::FID_W-1:0] msg_frame_id
);
	logic en_q;
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	// set once software could have enabled anything
	always_ff @(posedge clock) en_q <= rst ? 1'b0 : en_q | (reg_wr & (reg_addr == REG_MODE | reg_addr == REG_TEST));
	a_off_quiet: assert property (!en_q |-> !msg_valid) else $error("message while all off");
	a_test_sent: assert property (reg_wr && reg_addr == REG_TEST && reg_wdata[0] |-> ##[3:60] msg_valid && msg_event == EV_TEST) else $error("no test message");
	a_valid_held: assert property (msg_valid && !msg_ready |=> msg_valid) else $error("message dropped");
	a_data_held: assert property (msg_valid && !msg_ready |=> $stable(msg_event) && $stable(msg_frame_id)) else $error("message changed");
	a_stamp_rises: assert property (msg_valid && msg_ready ##1 msg_valid |-> msg_timestamp > $past(msg_timestamp)) else $error("stamp not unique");
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("read data outside slot");
	a_select_width: assert property (reg_rd && reg_addr == REG_SELECT |=> reg_rdata[31:6] == 26'h0) else $error("select too wide");
	a_event_range: assert property (msg_valid |-> msg_event < NUM_EVENTS) else $error("bad event id");
	c_stall: cover property (msg_valid && !msg_ready);
	c_test: cover property (msg_valid && msg_ready && msg_event == EV_TEST);
	c_read: cover property (reg_rd && reg_addr == REG_MODE);
endmodule : event_notify_assertions
bind device_event_notifier event_notify_assertions chk (.clock, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .msg_valid, .msg_ready, .msg_event, .msg_timestamp, .msg_frame_id);

// [testbench/device_event_notifier_test.sv]
`timescale 1ns/10ps
module device_event_notifier_test;
	import event_notify_pkg::*;
	typedef struct {int idx; notify_mode_t m; int n;} row_t;
	logic clock = 0, rst = 1, reg_wr = 0, reg_rd = 0, action_valid = 0, slow = 0;
	logic msg_valid, msg_ready, line_status_0, line_status_1;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, d, action_time = 32'h0, device_time = 32'h0, msg_timestamp;
	logic [42:0] direct_events = 43'h0;
	logic [1:0] encoder_step = 2'h0, io_pin = 2'h0, remote_trig = 2'h0;
	logic [15:0] frame_id = 16'h0, msg_frame_id, lf;
	logic [5:0] msg_event;
	logic [5:0] log_q [$];
	int errors = 0, n_checks = 0, b, e, cnt [64];
	row_t rows [6] = '{'{0, MODE_OFF, 0}, '{5, MODE_ON, 2}, '{21, MODE_ONCE, 1}, '{30, MODE_ON, 2},
		'{41, MODE_ONCE, 1}, '{42, MODE_ON, 2}};
	always #25 clock = ~clock;
	device_event_notifier dut (.clock, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .direct_events,
		.encoder_step, .io_pin, .remote_trig, .action_valid, .action_time, .device_time, .frame_id, .msg_valid,
		.msg_ready, .msg_event, .msg_timestamp, .msg_frame_id, .line_status_0, .line_status_1);
	host_sink sink (.clock, .rst, .slow, .msg_ready);
	// tally what the host really took
	always @(posedge clock) if (msg_valid === 1'b1 && msg_ready === 1'b1) begin
		cnt[msg_event]++;
		log_q.push_back(msg_event);
		lf = msg_frame_id;
	end
	task chk(logic [31:0] g, logic [31:0] x);
		n_checks++;
		if (g !== x) begin
			errors++;
			$display("unexpected at %0t: got %h exp %h", $time, g, x);
		end
	endtask : chk
	task end_sim;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : end_sim
	task settle; repeat (20) @(posedge clock); endtask : settle
	task wr(logic [3:0] a, logic [31:0] v);
		@(posedge clock) begin reg_addr <= a; reg_wdata <= v; reg_wr <= 1; end
		@(posedge clock) reg_wr <= 0;
	endtask : wr
	task rd(logic [3:0] a);
		@(posedge clock) begin reg_addr <= a; reg_rd <= 1; end
		@(posedge clock) reg_rd <= 0;
		@(negedge clock) d = reg_rdata;
	endtask : rd
	task md(int i, notify_mode_t m); wr(REG_SELECT, i); wr(REG_MODE, {30'h0, m}); endtask : md
	task pulse(int i);
		@(posedge clock) direct_events[i] <= 1;
		@(posedge clock) direct_events <= 0;
		settle;
	endtask : pulse
	// a hang counts as a mismatch
	initial begin repeat (20000) @(posedge clock); errors++; end_sim; end
	// main sequence
	initial begin
		repeat (16) @(posedge clock);
		rst <= 0;
		rd(REG_STALL); chk(d, 32'h1000);
		rd(4'hf); chk(d, 0);
		foreach (rows[i]) begin
			slow <= i[0];
			md(rows[i].idx, rows[i].m);
			b = cnt[rows[i].idx];
			pulse(rows[i].idx);
			pulse(rows[i].idx);
			chk(cnt[rows[i].idx] - b, rows[i].n);
			rd(REG_MODE); chk(d, rows[i].m == MODE_ONCE ? 0 : rows[i].m);
		end
		// once, hit in two adjacent cycles, reports one
		md(6, MODE_ONCE); b = cnt[6];
		@(posedge clock) direct_events[6] <= 1;
		pulse(6); chk(cnt[6] - b, 1);
		// test event with its mode never set
		frame_id <= 16'h00a5; b = cnt[EV_TEST];
		wr(REG_TEST, 1); settle; chk(cnt[EV_TEST] - b, 1);
		chk(lf, 16'h00a5);
		// two sources in one cycle leave lowest first
		md(3, MODE_ON); md(4, MODE_ON); log_q.delete();
		@(posedge clock) direct_events[4:3] <= 2'h3;
		@(posedge clock) direct_events <= 0;
		settle; chk({log_q[0], log_q[1]}, 12'h0c4);
		// rise, fall, either on a pin then a remote trigger
		for (int k = 0; k < 2; k++) begin
			e = k ? EV_RT_RISE : EV_PIN_RISE;
			md(e, MODE_ON); md(e + 2, MODE_ON); md(e + 4, MODE_ON);
			for (int v = 1; v >= 0; v--) begin if (k) remote_trig[0] <= v[0]; else io_pin[0] <= v[0]; settle; end
			chk(cnt[e] * 100 + cnt[e + 2] * 10 + cnt[e + 4], 112);
		end
		// inverting a low pin looks like a rising edge
		wr(REG_INVERT, 1); settle; chk(line_status_0, 1);
		chk(cnt[EV_PIN_RISE], 2);
		// both lines inverted and low read high; queue idle in the status word
		wr(REG_INVERT, 3); settle; chk(line_status_1, 1);
		rd(REG_PENDING); chk(d, 32'h6);
		// only an action time already past is late
		md(EV_LATE, MODE_ON); b = cnt[EV_LATE];
		for (int t = 8; t <= 9; t++) begin
			@(posedge clock) begin action_time <= t; device_time <= 9; action_valid <= 1; end
			@(posedge clock) action_valid <= 0;
			settle;
		end
		chk(cnt[EV_LATE] - b, 1);
		// encoder goes idle past the timeout then moves again
		wr(REG_STALL, 10); md(EV_ENC_STOP, MODE_ON); md(EV_ENC_RUN, MODE_ON);
		encoder_step[0] <= 1; repeat (5) @(posedge clock); b = cnt[EV_ENC_STOP];
		settle; chk(cnt[EV_ENC_STOP] - b, 1);
		b = cnt[EV_ENC_RUN]; encoder_step[0] <= 0; settle; chk(cnt[EV_ENC_RUN] - b, 1);
		end_sim;
	end
endmodule : device_event_notifier_test
